/* File: logic/acd_top.sv */
// Converter channel setup, modulator clock and decimation behind an AXI4-Lite slave.
//
// How it works
// - Modulator clock is half the controller clock.
// - Each bitstream is decimated by the selected ratio.
// - A three-bit field picks ratio 128 to 16384.
// - Decimation is a linear-phase FIR sinc averaging filter.
// - Two-bit power field picks the bias current mode.
// - Per-channel two-bit selector: pins, ground or a test signal.
// - Each channel's gain field picks 1 to 128.
// - No conversion data leave before the reference has settled.
// - Ratios 2048 and up use sinc3 by 1024 then sinc1 by 2 to 16.
//
// Local design decisions: the AXI4-Lite register port and the address map.
`include "acd_params.svh"
`default_nettype none
module acd_top #(
  parameter int NCH = 8,
  parameter int FIFO_DEPTH = 16,
  parameter int REF_SETTLE_CYC = `ACD_REF_SETTLE_CYC
) (
  input wire logic clk_sys, // Controller clock.
  input wire logic nrst, // Asynchronous reset, active low.
  input wire logic [7:0] s_axi_awaddr, // Write address.
  input wire logic s_axi_awvalid, // Write address valid.
  output logic s_axi_awready, // Write address ready.
  input wire logic [31:0] s_axi_wdata, // Write data.
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
  input wire logic s_axi_wvalid, // Write data valid.
  output logic s_axi_wready, // Write data ready.
  output logic [1:0] s_axi_bresp, // Write response.
  output logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_bready, // Write response ready.
  input wire logic [7:0] s_axi_araddr, // Read address.
  input wire logic s_axi_arvalid, // Read address valid.
  output logic s_axi_arready, // Read address ready.
  output logic [31:0] s_axi_rdata, // Read data.
  output logic [1:0] s_axi_rresp, // Read response.
  output logic s_axi_rvalid, // Read data valid.
  input wire logic s_axi_rready, // Read data ready.
  output logic mod_clk, // Modulator sampling clock.
  input wire logic [NCH-1:0] mod_bits, // Modulator bitstreams, asynchronous.
  output logic [2*NCH-1:0] channel_input_select, // Two bits per channel.
  output logic [3*NCH-1:0] channel_gain_select, // Three bits per channel.
  output logic [1:0] power_level_field // Bias current setting.
);
  ////////////////////////////////////////////////////////////////
  // Register state.
  logic [31:0] clock_cfg_reg, clock_cfg_next, chan_cfg_reg, chan_cfg_next, gain_reg, gain_next;
  logic overrun_reg, overrun_next;
  logic aw_held_reg, aw_held_next, w_held_reg, w_held_next;
  logic [7:0] awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic cfg_written, fifo_pop, push_overrun;
  logic [2:0] osr_code;

  // Applies the write strobes byte by byte.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////
  // Reference settle timer and modulator clock divider.
  logic [$clog2(REF_SETTLE_CYC+1)-1:0] settle_cnt_reg, settle_cnt_next;
  logic settled, mod_phase_reg, mod_phase_next, mod_tick;
  logic [NCH-1:0] bits_meta_reg, bits_sync_reg;

  always_comb begin
    settled = (settle_cnt_reg == REF_SETTLE_CYC[$bits(settle_cnt_reg)-1:0]);
    settle_cnt_next = settled ? settle_cnt_reg : settle_cnt_reg + 1'b1;
    mod_phase_next = ~mod_phase_reg;
    mod_tick = mod_phase_reg; // One sample every second controller clock.
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      settle_cnt_reg <= '0;
      mod_phase_reg <= 1'b0;
      bits_meta_reg <= '0;
      bits_sync_reg <= '0;
    end else begin
      settle_cnt_reg <= settle_cnt_next;
      mod_phase_reg <= mod_phase_next;
      bits_meta_reg <= mod_bits;
      bits_sync_reg <= bits_meta_reg;
    end
  end

  // The modulator latches its bit on the rising edge of this clock.
  assign mod_clk = mod_phase_reg;

  ////////////////////////////////////////////////////////////////
  // Decimation window counters. Codes 0..3 run sinc3 alone; 4..7 add sinc1.
  logic [9:0] cnt3_reg, cnt3_next, len3;
  logic [3:0] cnt1_reg, cnt1_next, len1;
  logic sinc1_on, dec3_tick, sinc1_last;
  logic [5:0] shamt;

  always_comb begin
    sinc1_on = osr_code[2];
    // Code k gives ratio 128 shl k.
    len3 = sinc1_on ? 10'h3ff : 10'((10'h080 << osr_code[1:0]) - 10'h001);
    len1 = 4'((5'h02 << osr_code[1:0]) - 5'h01);
    // Shift full scale up to bit 34.
    shamt = sinc1_on ? 6'(6'h03 - {4'h0, osr_code[1:0]}) : 6'(6'h0d - 6'(3 * osr_code[1:0]));
    dec3_tick = mod_tick && (cnt3_reg == len3);
    sinc1_last = (cnt1_reg == len1);
    cnt3_next = cnt3_reg;
    cnt1_next = cnt1_reg;
    if (cfg_written) begin
      cnt3_next = '0;
      cnt1_next = '0;
    end else if (mod_tick) begin
      cnt3_next = dec3_tick ? 10'h000 : cnt3_reg + 10'h001;
      if (dec3_tick && sinc1_on) begin
        cnt1_next = sinc1_last ? 4'h0 : cnt1_reg + 4'h1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cnt3_reg <= '0;
      cnt1_reg <= '0;
    end else begin
      cnt3_reg <= cnt3_next;
      cnt1_reg <= cnt1_next;
    end
  end

  ////////////////////////////////////////////////////////////////
  // One filter per channel, all on the same window so samples stay simultaneous.
  logic [23:0] chan_sample [NCH];
  logic [NCH-1:0] chan_done;

  for (genvar ch = 0; ch < NCH; ch++) begin : g_chan
    acd_sinc_chan u_sinc (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .clear(cfg_written),
      .mod_tick(mod_tick),
      .bit_in(bits_sync_reg[ch]),
      .dec3_tick(dec3_tick),
      .sinc1_on(sinc1_on),
      .sinc1_last(sinc1_last),
      .shamt(shamt),
      .sample(chan_sample[ch]),
      .done(chan_done[ch])
    );
  end

  ////////////////////////////////////////////////////////////////
  // Unloader: queues a frame, one word per cycle.
  acd_pkg::acd_state_t state_reg, state_next;
  logic [2:0] idx_reg, idx_next;
  logic [23:0] frame_reg [NCH];
  logic fifo_in_ready, fifo_out_valid;
  logic [31:0] fifo_out_data, fifo_in_data;

  always_comb begin
    state_next = state_reg;
    idx_next = idx_reg;
    push_overrun = 1'b0;
    fifo_in_data = {5'h00, idx_reg, frame_reg[idx_reg]};
    case (state_reg)
      acd_pkg::ACD_IDLE: begin
        // Frames before the reference settles are dropped.
        if (chan_done[0] && settled) begin
          state_next = acd_pkg::ACD_PUSH;
          idx_next = '0;
        end
      end
      acd_pkg::ACD_PUSH: begin
        // A full FIFO stalls here; a frame arriving meanwhile is lost and flagged.
        push_overrun = chan_done[0];
        if (fifo_in_ready) begin
          idx_next = idx_reg + 3'h1;
          if (idx_reg == 3'(NCH - 1)) begin
            state_next = acd_pkg::ACD_IDLE;
          end
        end
      end
      default: state_next = acd_pkg::ACD_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_reg <= acd_pkg::ACD_IDLE;
      idx_reg <= '0;
    end else begin
      state_reg <= state_next;
      idx_reg <= idx_next;
    end
  end

  // Frame copy is taken on every new frame seen in idle, settled or not, so it has no reset.
  always_ff @(posedge clk_sys) begin
    if (state_reg == acd_pkg::ACD_IDLE && chan_done[0]) begin
      frame_reg <= chan_sample;
    end
  end

  acd_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .in_valid(state_reg == acd_pkg::ACD_PUSH),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data)
  );

  ////////////////////////////////////////////////////////////////
  // AXI4-Lite slave: address and data taken in either order.
  logic do_write, do_read;

  always_comb begin
    aw_held_next = aw_held_reg || s_axi_awvalid;
    w_held_next = w_held_reg || s_axi_wvalid;
    awaddr_next = (!aw_held_reg && s_axi_awvalid) ? s_axi_awaddr : awaddr_reg;
    wdata_next = (!w_held_reg && s_axi_wvalid) ? s_axi_wdata : wdata_reg;
    wstrb_next = (!w_held_reg && s_axi_wvalid) ? s_axi_wstrb : wstrb_reg;
    do_write = aw_held_reg && w_held_reg && !bvalid_reg;
    clock_cfg_next = clock_cfg_reg;
    chan_cfg_next = chan_cfg_reg;
    gain_next = gain_reg;
    bvalid_next = bvalid_reg && !s_axi_bready;
    bresp_next = bresp_reg;
    cfg_written = 1'b0;
    // Set wins over a clear in the same cycle.
    overrun_next = overrun_reg || push_overrun;
    if (do_write) begin
      aw_held_next = 1'b0;
      w_held_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = `ACD_RESP_OKAY;
      if (awaddr_reg == `ACD_OFF_CLOCK_CFG) begin
        // Ratio and power fields; a change restarts the filters.
        clock_cfg_next = merge(clock_cfg_reg, wdata_reg, wstrb_reg) & 32'h0000_0307;
        cfg_written = 1'b1;
      end else if (awaddr_reg == `ACD_OFF_CHAN_CFG) begin
        chan_cfg_next = merge(chan_cfg_reg, wdata_reg, wstrb_reg) & 32'h0000_ffff;
      end else if (awaddr_reg == `ACD_OFF_GAIN) begin
        gain_next = merge(gain_reg, wdata_reg, wstrb_reg) & 32'h7777_7777;
      end else if (awaddr_reg == `ACD_OFF_STATUS) begin
        if (wstrb_reg[0] && wdata_reg[`ACD_ST_OVERRUN]) begin
          overrun_next = push_overrun;
        end
      end else begin
        bresp_next = `ACD_RESP_SLVERR;
      end
    end
  end

  always_comb begin
    do_read = s_axi_arvalid && !rvalid_reg;
    rvalid_next = rvalid_reg && !s_axi_rready;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    fifo_pop = 1'b0;
    if (do_read) begin
      rvalid_next = 1'b1;
      rresp_next = `ACD_RESP_OKAY;
      if (s_axi_araddr == `ACD_OFF_CLOCK_CFG) begin
        rdata_next = clock_cfg_reg;
      end else if (s_axi_araddr == `ACD_OFF_CHAN_CFG) begin
        rdata_next = chan_cfg_reg;
      end else if (s_axi_araddr == `ACD_OFF_GAIN) begin
        rdata_next = gain_reg;
      end else if (s_axi_araddr == `ACD_OFF_STATUS) begin
        rdata_next = {29'h0, fifo_out_valid, overrun_reg, settled};
      end else if (s_axi_araddr == `ACD_OFF_DATA) begin
        // Reading an empty FIFO returns zero and pops nothing.
        rdata_next = fifo_out_valid ? fifo_out_data : 32'h0000_0000;
        fifo_pop = fifo_out_valid;
      end else begin
        rdata_next = 32'h0000_0000;
        rresp_next = `ACD_RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      clock_cfg_reg <= {22'h0, `ACD_PWR_RESET, 5'h0, `ACD_OSR_RESET};
      chan_cfg_reg <= `ACD_CHAN_CFG_RESET;
      gain_reg <= `ACD_GAIN_RESET;
      overrun_reg <= 1'b0;
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `ACD_RESP_OKAY;
      rvalid_reg <= 1'b0;
      rresp_reg <= `ACD_RESP_OKAY;
      rdata_reg <= '0;
    end else begin
      clock_cfg_reg <= clock_cfg_next;
      chan_cfg_reg <= chan_cfg_next;
      gain_reg <= gain_next;
      overrun_reg <= overrun_next;
      aw_held_reg <= aw_held_next;
      w_held_reg <= w_held_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
    end
  end

  assign s_axi_awready = !aw_held_reg;
  assign s_axi_wready = !w_held_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;

  ////////////////////////////////////////////////////////////////
  // Analog controls come straight from the registers.
  assign osr_code = clock_cfg_reg[`ACD_OSR_LSB +: 3];
  assign power_level_field = clock_cfg_reg[`ACD_PWR_LSB +: 2];
  for (genvar ch = 0; ch < NCH; ch++) begin : g_ctrl
    assign channel_input_select[2*ch +: 2] = chan_cfg_reg[`ACD_SEL_PITCH*ch +: 2];
    assign channel_gain_select[3*ch +: 3] = gain_reg[`ACD_GAIN_PITCH*ch +: 3];
  end
endmodule
`default_nettype wire

/* File: common/acd_params.svh */
// Offsets, fields, reset values and timing counts.
`ifndef ACD_PARAMS_SVH
`define ACD_PARAMS_SVH

// Register byte offsets.
`define ACD_OFF_CLOCK_CFG 8'h00
`define ACD_OFF_CHAN_CFG 8'h04
`define ACD_OFF_GAIN 8'h08
`define ACD_OFF_STATUS 8'h0c
`define ACD_OFF_DATA 8'h10

// Field positions in the clock configuration register.
`define ACD_OSR_LSB 0
`define ACD_PWR_LSB 8

// Per-channel field pitch.
`define ACD_SEL_PITCH 2
`define ACD_GAIN_PITCH 4

// Reset values.
`define ACD_OSR_RESET 3'h1
`define ACD_PWR_RESET 2'h2
`define ACD_CHAN_CFG_RESET 32'h0000_0000
`define ACD_GAIN_RESET 32'h0000_0000

// Status bits.
`define ACD_ST_SETTLED 0
`define ACD_ST_OVERRUN 1
`define ACD_ST_NONEMPTY 2

// Clock rate and reference settling time.
`define ACD_CLK_HZ 20000000
`define ACD_REF_SETTLE_NS 10000
`define ACD_REF_SETTLE_CYC ((`ACD_REF_SETTLE_NS * (`ACD_CLK_HZ / 1000000) + 999) / 1000)

// Controller clocks per modulator clock.
`define ACD_MOD_DIV 2

// AXI responses.
`define ACD_RESP_OKAY 2'h0
`define ACD_RESP_SLVERR 2'h2

`endif

/* File: common/acd_pkg.sv */
// Types shared by the converter control block.
`default_nettype none
package acd_pkg;
  // Power setting codes, bias currents only.
  typedef enum logic [1:0] {
    ACD_VERY_LOW_POWER_MODE = 2'h0,
    ACD_LOW_POWER_MODE = 2'h1,
    ACD_HIGH_RESOLUTION_MODE = 2'h2
  } acd_power_t;

  // Sample unloader states.
  typedef enum logic {ACD_IDLE, ACD_PUSH} acd_state_t;
endpackage
`default_nettype wire

/* File: logic/acd_fifo.sv */
// Sample FIFO with a registered read port.
`default_nettype none
module acd_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys, // Controller clock.
  input wire logic nrst, // Asynchronous reset, active low.
  input wire logic in_valid, // Write request.
  output logic in_ready, // Not full.
  input wire logic [WIDTH-1:0] in_data, // Write word.
  output logic out_valid, // Not empty.
  input wire logic out_ready, // Pop request.
  output logic [WIDTH-1:0] out_data // Head word.
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wptr_reg, wptr_next, rptr_reg, rptr_next;
  logic [AW:0] count_reg, count_next;
  logic [WIDTH-1:0] head_reg;
  logic do_wr, do_rd;

  ////////////////////////////////////////////////////////////////
  // Pointer and count update; a push and a pop may share a cycle.
  always_comb begin
    do_wr = in_valid && in_ready;
    do_rd = out_valid && out_ready;
    wptr_next = do_wr ? wptr_reg + 1'b1 : wptr_reg;
    rptr_next = do_rd ? rptr_reg + 1'b1 : rptr_reg;
    count_next = count_reg + {{AW{1'b0}}, do_wr} - {{AW{1'b0}}, do_rd};
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      count_reg <= '0;
    end else begin
      wptr_reg <= wptr_next;
      rptr_reg <= rptr_next;
      count_reg <= count_next;
    end
  end

  // Storage has no reset so it maps onto plain RAM cells.
  always_ff @(posedge clk_sys) begin
    if (do_wr) begin
      mem[wptr_reg] <= in_data;
    end
  end

  // Registered head; a word pushed into an empty FIFO shows a cycle later.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      head_reg <= '0;
    end else begin
      head_reg <= mem[rptr_next];
    end
  end

  logic shown_reg;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      shown_reg <= 1'b0;
    end else begin
      shown_reg <= (count_next != '0) && !(do_wr && count_reg == '0) && !(do_wr && do_rd && count_reg == 1);
    end
  end

  assign in_ready = (count_reg != DEPTH[AW:0]);
  assign out_valid = shown_reg;
  assign out_data = head_reg;
endmodule
`default_nettype wire

/* File: logic/acd_sinc_chan.sv */
// One decimator channel: sinc3 integrator-comb and optional sinc1 averager.
`default_nettype none
module acd_sinc_chan #(
  parameter int IW = 31,
  parameter int AW = 35
) (
  input wire logic clk_sys, // Controller clock.
  input wire logic nrst, // Asynchronous reset, active low.
  input wire logic clear, // Restart the filter state.
  input wire logic mod_tick, // One pulse per modulator sample.
  input wire logic bit_in, // Synchronised modulator bit.
  input wire logic dec3_tick, // Last sample of a sinc3 window.
  input wire logic sinc1_on, // Second stage in use.
  input wire logic sinc1_last, // Last sinc3 output of a sinc1 window.
  input wire logic [5:0] shamt, // Left shift to full scale.
  output logic [23:0] sample, // Signed output sample.
  output logic done // One-cycle pulse with a new sample.
);
  logic [IW-1:0] i1_reg, i2_reg, i3_reg, d1_reg, d2_reg, d3_reg;
  logic [IW-1:0] i1_next, i2_next, i3_next, d1_next, d2_next, d3_next;
  logic [IW-1:0] c1, c2, c3;
  logic [AW-1:0] acc_reg, acc_next, sum;
  logic [23:0] sample_reg, sample_next;
  logic done_reg, done_next;
  logic [35:0] wide, cent;

  ////////////////////////////////////////////////////////////////
  // Integrators run at the modulator rate, combs at the decimated rate.
  always_comb begin
    i1_next = i1_reg;
    i2_next = i2_reg;
    i3_next = i3_reg;
    d1_next = d1_reg;
    d2_next = d2_reg;
    d3_next = d3_reg;
    acc_next = acc_reg;
    sample_next = sample_reg;
    done_next = 1'b0;
    c1 = i3_reg - d1_reg;
    c2 = c1 - d2_reg;
    c3 = c2 - d3_reg;
    sum = acc_reg + {{(AW-IW){1'b0}}, c3};
    wide = '0;
    cent = '0;
    if (clear) begin
      i1_next = '0;
      i2_next = '0;
      i3_next = '0;
      d1_next = '0;
      d2_next = '0;
      d3_next = '0;
      acc_next = '0;
    end else if (mod_tick) begin
      // Averaging the bitstream three times gives a linear-phase FIR low-pass.
      i1_next = i1_reg + {{(IW-1){1'b0}}, bit_in};
      i2_next = i2_reg + i1_reg;
      i3_next = i3_reg + i2_reg;
      if (dec3_tick) begin
        // Downsample once per window.
        d1_next = i3_reg;
        d2_next = c1;
        d3_next = c2;
        if (sinc1_on && !sinc1_last) begin
          acc_next = sum;
        end else begin
          acc_next = '0;
          wide = (sinc1_on ? {1'b0, sum} : {{(36-IW){1'b0}}, c3}) << shamt;
          cent = wide - 36'h2_0000_0000;
          // Full ones density is the only value past positive full scale.
          sample_next = wide[34] ? 24'h7f_ffff : cent[33:10];
          done_next = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      i1_reg <= '0;
      i2_reg <= '0;
      i3_reg <= '0;
      d1_reg <= '0;
      d2_reg <= '0;
      d3_reg <= '0;
      acc_reg <= '0;
      sample_reg <= '0;
      done_reg <= 1'b0;
    end else begin
      i1_reg <= i1_next;
      i2_reg <= i2_next;
      i3_reg <= i3_next;
      d1_reg <= d1_next;
      d2_reg <= d2_next;
      d3_reg <= d3_next;
      acc_reg <= acc_next;
      sample_reg <= sample_next;
      done_reg <= done_next;
    end
  end

  assign sample = sample_reg;
  assign done = done_reg;
endmodule
`default_nettype wire

/* File: testbench/acd_mod_model.sv */
// Behavioural stand-in for the eight analog modulators.
`default_nettype none
module acd_mod_model (
  input wire logic mod_clk, // Modulator clock from the block.
  input wire logic [7:0] ones, // One bit per channel: all ones, else alternating.
  output logic [7:0] mod_bits // Bitstreams to the block.
);
  timeunit 1ns;
  timeprecision 1ns;
  initial mod_bits = 8'h00;
  // Bits move on the falling edge, away from the sampling point.
  always @(negedge mod_clk) mod_bits <= ones | ~mod_bits;
endmodule
`default_nettype wire

/* File: testbench/acd_top_asserts.sv */
// Port checker for the converter control block.
`include "acd_params.svh"
`default_nettype none
module acd_top_asserts #(
  parameter int REF_SETTLE_CYC = 200
) (
  input wire logic clk_sys, // Clock.
  input wire logic nrst, // Reset.
  input wire logic [7:0] s_axi_awaddr, // Bus.
  input wire logic s_axi_awvalid, // Bus.
  input wire logic s_axi_awready, // Bus.
  input wire logic [31:0] s_axi_wdata, // Bus.
  input wire logic s_axi_wvalid, // Bus.
  input wire logic s_axi_wready, // Bus.
  input wire logic [1:0] s_axi_bresp, // Bus.
  input wire logic s_axi_bvalid, // Bus.
  input wire logic [7:0] s_axi_araddr, // Bus.
  input wire logic s_axi_arvalid, // Bus.
  input wire logic s_axi_arready, // Bus.
  input wire logic [31:0] s_axi_rdata, // Bus.
  input wire logic s_axi_rvalid, // Bus.
  input wire logic mod_clk, // Modulator clock.
  input wire logic [15:0] channel_input_select, // Selectors.
  input wire logic [23:0] channel_gain_select, // Gains.
  input wire logic [1:0] power_level_field // Bias.
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] wa_q, ra_q;
  logic [31:0] wd_q;
  logic [15:0] cyc_q;
  logic [23:0] gain_exp;
  logic wr_ok;
  // Last request, so each answer can be tied to it.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wa_q <= 8'h00;
      wd_q <= 32'h0;
      ra_q <= 8'h00;
      cyc_q <= 16'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready) begin
        wa_q <= s_axi_awaddr;
        wd_q <= s_axi_wdata;
      end
      if (s_axi_arvalid && s_axi_arready) ra_q <= s_axi_araddr;
      if (cyc_q != 16'hffff) cyc_q <= cyc_q + 16'h1;
    end
  end
  // Low three bits of each gain nibble.
  always_comb begin
    for (int n = 0; n < 8; n++) gain_exp[3*n +: 3] = wd_q[4*n +: 3];
  end
  assign wr_ok = s_axi_bresp == `ACD_RESP_OKAY;
  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  property p_mod_fall; mod_clk |=> !mod_clk; endproperty
  a_mod_fall: assert property (p_mod_fall) else $error("modulator clock high twice");
  property p_mod_rise; !mod_clk ##1 !mod_clk |=> mod_clk; endproperty
  a_mod_rise: assert property (p_mod_rise) else $error("modulator clock stuck low");
  property p_sel; $rose(s_axi_bvalid) && wr_ok && wa_q == `ACD_OFF_CHAN_CFG |=> channel_input_select == wd_q[15:0];
  endproperty
  a_sel: assert property (p_sel) else $error("selector output wrong");
  property p_gain; $rose(s_axi_bvalid) && wr_ok && wa_q == `ACD_OFF_GAIN |=> channel_gain_select == gain_exp; endproperty
  a_gain: assert property (p_gain) else $error("gain output wrong");
  property p_pwr; $rose(s_axi_bvalid) && wr_ok && wa_q == 8'h00 |=> power_level_field == wd_q[9:8]; endproperty
  a_pwr: assert property (p_pwr) else $error("power output wrong");
  property p_early; s_axi_rvalid && ra_q == `ACD_OFF_STATUS && cyc_q < REF_SETTLE_CYC - 2 |-> s_axi_rdata[2:0] == 3'h0;
  endproperty
  a_early: assert property (p_early) else $error("settled too soon");
  property p_late; s_axi_rvalid && ra_q == `ACD_OFF_STATUS && cyc_q > REF_SETTLE_CYC + 4 |-> s_axi_rdata[0]; endproperty
  a_late: assert property (p_late) else $error("never settled");
  property p_nodata; s_axi_rvalid && ra_q == `ACD_OFF_DATA && cyc_q < REF_SETTLE_CYC - 2 |-> s_axi_rdata == 32'h0;
  endproperty
  a_nodata: assert property (p_nodata) else $error("data before settling");
  cover property (s_axi_bvalid && s_axi_bresp == `ACD_RESP_SLVERR);
  cover property (s_axi_rvalid && ra_q == `ACD_OFF_DATA && s_axi_rdata[23:0] == 24'h7fffff);
  cover property ($rose(s_axi_bvalid) && wa_q == `ACD_OFF_GAIN);
endmodule
bind acd_top acd_top_asserts #(.REF_SETTLE_CYC(REF_SETTLE_CYC)) u_asserts (.*);
`default_nettype wire

/* File: testbench/tb_acd_top.sv */
// Self-checking bench for the converter control block.
`include "acd_params.svh"
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
  $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e); end end
module tb_acd_top;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [7:0] a; logic [31:0] w, r; logic [1:0] s; logic [39:0] o;} acd_row_t;
  localparam logic [7:0] CF = `ACD_OFF_CLOCK_CFG, ST = `ACD_OFF_STATUS, DT = `ACD_OFF_DATA;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, mod_bits;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, mod_clk;
  logic [1:0] s_axi_bresp, s_axi_rresp, power_level_field, rsp;
  logic [15:0] channel_input_select;
  logic [23:0] channel_gain_select;
  logic [2:0] codes [2] = '{3'h0, 3'h4};
  int miscompares = 0, tests_run = 0, el;
  time t0;
  // Address, write, read, response, selector and gain outputs.
  acd_row_t rows [4] = '{
    '{`ACD_OFF_CHAN_CFG, 32'he4e4, 32'he4e4, 2'h0, 40'he4e4000000},
    '{`ACD_OFF_GAIN, 32'hffff_ffff, 32'h7777_7777, 2'h0, 40'he4e4ffffff},
    '{`ACD_OFF_GAIN, 32'h7654_3210, 32'h7654_3210, 2'h0, 40'he4e4fac688},
    '{8'h14, 32'h1234_5678, 32'h0, `ACD_RESP_SLVERR, 40'he4e4fac688}};
  always #25 clk_sys = !clk_sys; // Steady external clock, no crystal.
  acd_top #(.REF_SETTLE_CYC(16)) DUT (.*);
  acd_mod_model u_mods (.mod_clk(mod_clk), .ones(8'hff), .mod_bits(mod_bits));
  ////////////////////////////////////////////////////////////////
  task automatic conclude;
    if (miscompares == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // One transfer; each channel holds until its own ready, a lost answer ends the run.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d = 32'h0);
    int n = 0;
    @(posedge clk_sys);
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= {wr, wr, wr, !wr, !wr};
    do begin
      @(posedge clk_sys);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!(wr ? s_axi_bvalid : s_axi_rvalid) && n < 100);
    rd = s_axi_rdata;
    rsp = wr ? s_axi_bresp : s_axi_rresp;
    {s_axi_bready, s_axi_rready} <= 2'h0;
    if (n >= 100) begin
      miscompares++;
      conclude();
    end
  endtask
  // Polls until the nonempty bit equals want; when draining, pops a word before each poll.
  task automatic poll(input logic want);
    int n = 0;
    do begin
      if (!want) bus(1'b0, DT);
      bus(1'b0, ST);
      n++;
    end while (rd[2] !== want && n < 3000);
    `CHK(rd[2], want)
    if (n >= 3000) conclude();
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk_sys);
    nrst <= 1'b1;
    foreach (rows[i]) begin
      bus(1'b1, rows[i].a, rows[i].w);
      `CHK(rsp, rows[i].s)
      bus(1'b0, rows[i].a);
      `CHK({rsp, rd}, {rows[i].s, rows[i].r})
      `CHK({channel_input_select, channel_gain_select}, rows[i].o)
    end
    for (int k = 0; k < 8; k++) begin
      bus(1'b1, CF, 32'(k % 3 * 256 + k));
      bus(1'b0, CF);
      `CHK({power_level_field, rd}, {2'(k % 3), 32'(k % 3 * 256 + k)})
    end
    // Mid-run reset; nothing may come out before settling.
    nrst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    nrst <= 1'b1;
    `CHK({power_level_field, channel_input_select, channel_gain_select}, {2'h2, 40'h0})
    bus(1'b0, ST);
    `CHK(rd, 32'h0)
    bus(1'b0, DT);
    `CHK(rd, 32'h0)
    bus(1'b0, CF);
    `CHK(rd, 32'h0000_0201)
    repeat (16) @(posedge clk_sys);
    bus(1'b0, ST);
    `CHK(rd[0], 1'b1)
    // Frame period doubles per code; code 4 uses both stages.
    foreach (codes[j]) begin
      bus(1'b1, CF, 32'h200 | codes[j]);
      t0 = $time;
      poll(1'h0);
      poll(1'h1);
      el = int'(($time - t0) / 50);
      `CHK(el >= (256 << codes[j]) - 4 && el <= (256 << codes[j]) + 40, 1'b1)
      for (int c = 0; c < 8; c++) begin
        bus(1'b0, DT);
        `CHK(rd[31:24], 8'(c))
      end
    end
    // Overflow, then drain and take a settled frame.
    repeat (5 * 4096) @(posedge clk_sys);
    bus(1'b0, ST);
    `CHK(rd[2:0], 3'h7)
    bus(1'b1, ST, 32'h2);
    poll(1'h0);
    poll(1'h1);
    for (int c = 0; c < 8; c++) begin
      bus(1'b0, DT);
      `CHK(rd, {5'h0, 3'(c), 24'h7fffff})
    end
    conclude();
  end
endmodule
`default_nettype wire
